/* File: rtl/lvds_seq_pkg.sv */
// Notes on behaviour
// R1: Port runs in single-channel or dual-channel mode; dual uses both channels.
// R2: Dual mode sends even pixels on channel A, odd pixels on channel B.
// R3: Pixel where display enable goes active always leaves on channel A.
// R4: Dual mode horizontal edges are applied only on two-pixel boundaries.
// R5: Shift rate is 7x pixel rate single, 3.5x dual, locked to pixel clock.
// R6: Load strobe every pixel single, every second pixel dual, tied to shifting.
// R7: Device drives panel supply enable and backlight power enable outputs.
// R8: One sequencer owns supply, backlight and link clock/data activity.
// R9: Power-up holds supply on for supply-to-link delay before link starts.
// R10: Power-up keeps link active for link-to-backlight delay before backlight on.
// R11: Power-down drops backlight, waits backlight-off delay, then stops link.
// R12: After link stops, wait link-off delay before supply turns off.
// R13: After supply off, new power-up waits until power-cycle delay elapsed.
// R14: Both channels share one load and shift timing in dual mode.
// R15: Disabled port powers all pairs down; unused pairs off or sending zeros.
// R16: Each sequencing delay is a programmable count timed by an internal timer.
package lvds_seq_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_MHZ = 25;
    localparam int TICK_TIME_US = 100;
    localparam int TICK_CYCLES = TICK_TIME_US * CLOCK_MHZ;
    localparam int PRE_W = 12;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam int DLY_W = 16;
    localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;

    // ****************************************************************
    // Pixel and lane layout
    // ****************************************************************
    localparam int COLOR_W = 6;
    localparam int PIX_W = 3 * COLOR_W;
    localparam int WORD_W = 21;
    localparam int BITS_PER_LOAD = 7;
    localparam int LANE0_POS = 0;
    localparam int LANE1_POS = 7;
    localparam int LANE2_POS = 14;
    localparam logic [2:0] SHIFT_LAST = 3'h6;
    localparam logic [6:0] CLK_PATTERN = 7'h63;
    localparam logic [WORD_W-1:0] WORD_ZERO = 21'h00_0000;
    localparam logic [3:0] PAIRS_OFF = 4'h0;
    localparam logic [3:0] PAIRS_ON = 4'hf;

    // ****************************************************************
    // Sequencer states, Gray coded along the on/off path except the CYCLE to OFF step
    // ****************************************************************
    typedef enum logic [2:0] {
        SEQ_OFF = 3'h0,
        SEQ_SUPPLY = 3'h1,
        SEQ_LINK = 3'h3,
        SEQ_ON = 3'h2,
        SEQ_BL_OFF = 3'h6,
        SEQ_LINK_OFF = 3'h7,
        SEQ_CYCLE = 3'h5
    } seq_state_t;

endpackage

/* File: rtl/seq_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module seq_delay_timer (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_count,
    output logic o_done
);
    import lvds_seq_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DLY_W-1:0] cnt;
        logic done;
    } timer_t;

    timer_t q;
    timer_t d;

    // Prescaler restarts on load so every tick is a whole tick
    always_comb begin
        d = q;
        if (i_load) begin
            d.pre = '0;
            d.cnt = i_count;
            d.done = 1'b0;
        end else if (!q.done) begin
            if (q.cnt == DLY_ZERO) begin
                d.done = 1'b1;
            end else if (q.pre == PRE_LAST) begin
                d.pre = '0;
                d.cnt = q.cnt - 1'b1; // [R16]
            end else begin
                d.pre = q.pre + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '{pre: '0, cnt: '0, done: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign o_done = q.done;
endmodule // seq_delay_timer
`default_nettype wire

/* File: rtl/lvds_panel_port_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module lvds_panel_port_sequencer (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_pixel_clock,
    input wire logic [lvds_seq_pkg::PIX_W-1:0] i_pixel,
    input wire logic i_hsync,
    input wire logic i_vsync,
    input wire logic i_display_enable,
    input wire logic i_port_enable,
    input wire logic i_dual_mode,
    input wire logic i_unused_send_zeros,
    input wire logic i_power_request,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_supply_to_link_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_link_to_backlight_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_backlight_off_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_link_off_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_power_cycle_delay,
    output logic o_panel_supply_enable,
    output logic o_backlight_power_enable,
    output logic o_link_active,
    output logic [2:0] o_lane_a,
    output logic [2:0] o_lane_b,
    output logic o_link_clock_a,
    output logic o_link_clock_b,
    output logic o_load_strobe,
    output logic o_shift_strobe,
    output logic [3:0] o_pair_power_a,
    output logic [3:0] o_pair_power_b,
    output logic [2:0] o_seq_state
);
    import lvds_seq_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        seq_state_t seq;
        logic supply;
        logic bklt;
        logic link;
        logic timer_load;
        logic [DLY_W-1:0] timer_count;
        logic [2:0] pclk_sync;
        logic pclk_level;
        logic [WORD_W-1:0] in1;
        logic [WORD_W-1:0] in2;
        logic [WORD_W-1:0] in3;
        logic de_prev;
        logic odd;
        logic [PIX_W-1:0] even_pix;
        logic [2:0] even_ctrl;
        logic [WORD_W-1:0] sh_a;
        logic [WORD_W-1:0] sh_b;
        logic [6:0] sh_clk;
        logic [2:0] sh_cnt;
        logic shifting;
        logic [2:0] lane_a;
        logic [2:0] lane_b;
        logic lclk_a;
        logic lclk_b;
        logic load;
        logic shift;
        logic [3:0] pow_a;
        logic [3:0] pow_b;
    } port_t;

    port_t q;
    port_t d;
    logic timer_done;
    logic pclk_rise;
    logic want_on;
    logic [WORD_W-1:0] pix_now;
    logic de_now;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Packs one pixel and its control bits into three 7-bit lane words
    function automatic logic [WORD_W-1:0] pack_word(
        input logic [PIX_W-1:0] pix,
        input logic [2:0] ctrl
    );
        logic [COLOR_W-1:0] r;
        logic [COLOR_W-1:0] g;
        logic [COLOR_W-1:0] b;
        r = pix[3*COLOR_W-1:2*COLOR_W];
        g = pix[2*COLOR_W-1:COLOR_W];
        b = pix[COLOR_W-1:0];
        pack_word = {ctrl, b[5:2], b[1:0], g[5:1], g[0], r};
    endfunction

    // Picks the bit leaving a lane word at a given shift position
    function automatic logic [2:0] lane_bits(
        input logic [WORD_W-1:0] w,
        input logic [2:0] pos
    );
        logic [2:0] idx;
        idx = SHIFT_LAST - pos;
        lane_bits = {w[LANE2_POS + 32'(idx)], w[LANE1_POS + 32'(idx)],
                     w[LANE0_POS + 32'(idx)]};
    endfunction

    seq_delay_timer u_timer (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_load(q.timer_load),
        .i_count(q.timer_count),
        .o_done(timer_done)
    );

    // Pixel edge only after two late sync stages agree; first stage is not inspected
    assign pclk_rise = (q.pclk_sync[1] == q.pclk_sync[2]) && q.pclk_sync[1] && !q.pclk_level;
    assign pix_now = q.in3;
    assign de_now = q.in3[WORD_W-1];
    // Disabling the port also powers the panel down, so no pair idles powered
    assign want_on = i_power_request && i_port_enable;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.timer_load = 1'b0;
        d.load = 1'b0;
        d.shift = 1'b0;

        // Input capture through three stages
        d.pclk_sync = {q.pclk_sync[1:0], i_pixel_clock};
        if (q.pclk_sync[1] == q.pclk_sync[2]) begin
            d.pclk_level = q.pclk_sync[1];
        end
        d.in1 = {i_display_enable, i_vsync, i_hsync, i_pixel};
        d.in2 = q.in1;
        d.in3 = q.in2;

        // Power sequencer, the only owner of supply, backlight and link
        case (q.seq) // [R8]
            SEQ_OFF: begin
                if (want_on) begin
                    d.seq = SEQ_SUPPLY;
                    d.supply = 1'b1; // [R7]
                    d.timer_load = 1'b1;
                    d.timer_count = i_supply_to_link_delay; // [R16]
                end
            end
            SEQ_SUPPLY: begin
                if (!want_on) begin
                    // Supply up but link never started: straight to cycle wait
                    d.seq = SEQ_CYCLE;
                    d.supply = 1'b0;
                    d.timer_load = 1'b1;
                    d.timer_count = i_power_cycle_delay;
                end else if (timer_done && !q.timer_load) begin
                    d.seq = SEQ_LINK;
                    d.link = 1'b1; // [R9]
                    d.timer_load = 1'b1;
                    d.timer_count = i_link_to_backlight_delay;
                end
            end
            SEQ_LINK: begin
                // Backlight never came on here, so its off wait is skipped
                if (!want_on) begin
                    d.seq = SEQ_LINK_OFF;
                    d.link = 1'b0;
                    d.timer_load = 1'b1;
                    d.timer_count = i_link_off_delay;
                end else if (timer_done && !q.timer_load) begin
                    d.seq = SEQ_ON;
                    d.bklt = 1'b1; // [R10] [R7]
                end
            end
            SEQ_ON: begin
                if (!want_on) begin
                    d.seq = SEQ_BL_OFF;
                    d.bklt = 1'b0; // [R11]
                    d.timer_load = 1'b1;
                    d.timer_count = i_backlight_off_delay;
                end
            end
            SEQ_BL_OFF: begin
                // Off steps run to their end even if the request comes back
                if (timer_done && !q.timer_load) begin
                    d.seq = SEQ_LINK_OFF;
                    d.link = 1'b0; // [R11]
                    d.timer_load = 1'b1;
                    d.timer_count = i_link_off_delay;
                end
            end
            SEQ_LINK_OFF: begin
                if (timer_done && !q.timer_load) begin
                    d.seq = SEQ_CYCLE;
                    d.supply = 1'b0; // [R12]
                    d.timer_load = 1'b1;
                    d.timer_count = i_power_cycle_delay;
                end
            end
            SEQ_CYCLE: begin
                // Requests are held off here; a pending one starts from OFF
                if (timer_done && !q.timer_load) begin
                    d.seq = SEQ_OFF; // [R13]
                end
            end
            default: begin
                d.seq = SEQ_OFF;
                d.supply = 1'b0;
                d.bklt = 1'b0;
                d.link = 1'b0;
            end
        endcase

        // Pixel capture and load, one shared timing for both channels
        if (pclk_rise) begin
            d.pclk_level = 1'b1;
            d.de_prev = de_now;
            if (!i_dual_mode) begin
                d.sh_a = pix_now; // [R1]
                d.sh_b = WORD_ZERO;
                d.load = 1'b1; // [R6]
                d.odd = 1'b0;
            end else if (de_now && !q.de_prev) begin
                // Line start always takes the A slot
                d.even_pix = pix_now[PIX_W-1:0]; // [R3]
                d.even_ctrl = pix_now[WORD_W-1:PIX_W];
                d.odd = 1'b1;
            end else if (!q.odd) begin
                d.even_pix = pix_now[PIX_W-1:0]; // [R2]
                d.even_ctrl = pix_now[WORD_W-1:PIX_W];
                d.odd = 1'b1;
            end else begin
                // Control bits of the pair come from its even pixel
                d.sh_a = pack_word(q.even_pix, q.even_ctrl); // [R4] [R2]
                d.sh_b = pack_word(pix_now[PIX_W-1:0], q.even_ctrl); // [R4]
                d.load = 1'b1; // [R6] [R14]
                d.odd = 1'b0;
            end
            if (!i_dual_mode) begin
                d.sh_a = pack_word(pix_now[PIX_W-1:0], pix_now[WORD_W-1:PIX_W]);
            end
        end

        // Limitation: a pixel period under eight clocks single, or under four clocks dual, cuts a burst short
        // Seven shift steps per load: 7x per pixel single, 3.5x dual
        if (d.load) begin
            d.shifting = 1'b1; // [R5]
            d.sh_cnt = 3'h0;
            d.sh_clk = CLK_PATTERN;
        end else if (q.shifting) begin
            d.shift = 1'b1; // [R5]
            d.lane_a = q.link ? lane_bits(q.sh_a, q.sh_cnt) : 3'h0;
            d.lane_b = (q.link && i_dual_mode) ? lane_bits(q.sh_b, q.sh_cnt) : 3'h0; // [R14]
            d.lclk_a = q.link & q.sh_clk[6];
            d.lclk_b = q.link & i_dual_mode & q.sh_clk[6];
            d.sh_clk = {q.sh_clk[5:0], q.sh_clk[6]};
            if (q.sh_cnt == SHIFT_LAST) begin
                d.shifting = 1'b0;
            end else begin
                d.sh_cnt = q.sh_cnt + 1'b1;
            end
        end
        if (!q.link) begin
            // No clock and no data on the link outside the active window
            d.lane_a = 3'h0;
            d.lane_b = 3'h0;
            d.lclk_a = 1'b0;
            d.lclk_b = 1'b0;
        end

        // Pair power: B is unused in single mode, zeros option keeps it biased
        d.pow_a = i_port_enable ? PAIRS_ON : PAIRS_OFF; // [R15]
        d.pow_b = (i_port_enable && (i_dual_mode || i_unused_send_zeros)) ?
                  PAIRS_ON : PAIRS_OFF; // [R15] [R1]
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // One register for all state keeps every output straight from a flop
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_panel_supply_enable = q.supply;
    assign o_backlight_power_enable = q.bklt;
    assign o_link_active = q.link;
    assign o_lane_a = q.lane_a;
    assign o_lane_b = q.lane_b;
    assign o_link_clock_a = q.lclk_a;
    assign o_link_clock_b = q.lclk_b;
    assign o_load_strobe = q.load;
    assign o_shift_strobe = q.shift;
    assign o_pair_power_a = q.pow_a;
    assign o_pair_power_b = q.pow_b;
    assign o_seq_state = q.seq;
endmodule // lvds_panel_port_sequencer
`default_nettype wire

/* File: tb/lvds_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Sequencer and serializer timing checks
// ****************************************
module lvds_port_props (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_port_enable,
    input wire logic i_dual_mode,
    input wire logic i_power_request,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_supply_to_link_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_link_to_backlight_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_backlight_off_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_link_off_delay,
    input wire logic [lvds_seq_pkg::DLY_W-1:0] i_power_cycle_delay,
    input wire logic o_panel_supply_enable,
    input wire logic o_backlight_power_enable,
    input wire logic o_link_active,
    input wire logic o_link_clock_a,
    input wire logic o_link_clock_b,
    input wire logic o_load_strobe,
    input wire logic o_shift_strobe,
    input wire logic [3:0] o_pair_power_a,
    input wire logic [3:0] o_pair_power_b,
    input wire logic [2:0] o_seq_state
);
    import lvds_seq_pkg::*;
    logic [2:0] st_q;
    logic [31:0] age_q;
    // Edges spent in the present state; every minimum delay is judged on it
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= 3'h0;
            age_q <= 32'h0;
        end else begin
            st_q <= o_seq_state;
            age_q <= (o_seq_state != st_q) ? 32'h1 : age_q + 32'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    link_after_supply_a: assert property (
        $rose(o_link_active) |-> o_panel_supply_enable
            && age_q >= TICK_CYCLES * i_supply_to_link_delay)
        else $error("link started early");
    light_after_link_a: assert property (
        $rose(o_backlight_power_enable) |-> o_link_active
            && age_q >= TICK_CYCLES * i_link_to_backlight_delay)
        else $error("backlight on early");
    light_drop_a: assert property (
        o_seq_state == SEQ_ON && !(i_power_request && i_port_enable)
            |=> !o_backlight_power_enable)
        else $error("backlight kept on");
    link_stop_a: assert property (
        $fell(o_link_active) && st_q == SEQ_BL_OFF |-> !o_backlight_power_enable
            && age_q >= TICK_CYCLES * i_backlight_off_delay)
        else $error("link stopped early");
    supply_off_a: assert property (
        $fell(o_panel_supply_enable) && st_q == SEQ_LINK_OFF |-> !o_link_active
            && age_q >= TICK_CYCLES * i_link_off_delay)
        else $error("supply dropped early");
    cycle_wait_a: assert property (
        st_q == SEQ_CYCLE && o_seq_state != SEQ_CYCLE |-> o_seq_state == SEQ_OFF
            && age_q >= TICK_CYCLES * i_power_cycle_delay)
        else $error("power cycle cut short");
    shift_burst_a: assert property (
        o_load_strobe |=> (o_shift_strobe && !o_load_strobe) [*7])
        else $error("load without seven shifts");
    pairs_off_a: assert property (
        !i_port_enable && !$past(i_port_enable) |-> o_pair_power_a == PAIRS_OFF
            && o_pair_power_b == PAIRS_OFF)
        else $error("pairs powered while disabled");
    clock_pair_a: assert property (
        o_link_clock_b == (o_link_clock_a && i_dual_mode))
        else $error("channel clocks out of step");
endmodule // lvds_port_props

bind lvds_panel_port_sequencer lvds_port_props u_props (.*);
`default_nettype wire

/* File: tb/panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Panel receiver model
// ****************************************
module panel_model (
    input wire logic i_clock,
    input wire logic i_shift,
    input wire logic i_load,
    input wire logic [2:0] i_lane_a,
    input wire logic [2:0] i_lane_b,
    input wire logic i_clk_a,
    output logic [20:0] o_word_a,
    output logic [20:0] o_word_b,
    output logic [6:0] o_clk_a,
    output logic o_valid
);
    logic [2:0] n_q;
    // Both channels taken on one shared strobe, so skew shows as bad words
    always @(posedge i_clock) begin
        o_valid <= i_shift && n_q == 3'h6;
        if (i_load) n_q <= 3'h0;
        if (i_shift) begin
            n_q <= n_q + 3'h1;
            o_clk_a <= {o_clk_a[5:0], i_clk_a};
            for (int l = 0; l < 3; l++) begin
                o_word_a[7*l +: 7] <= {o_word_a[7*l +: 6], i_lane_a[l]};
                o_word_b[7*l +: 7] <= {o_word_b[7*l +: 6], i_lane_b[l]};
            end
        end
    end
endmodule // panel_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Panel port bench
// ****************************************
module tb_top;
    import lvds_seq_pkg::*;
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_pixel_clock = 1'b0;
    logic i_hsync = 1'b0, i_vsync = 1'b0, i_display_enable = 1'b0;
    logic i_port_enable = 1'b0, i_dual_mode = 1'b0, i_unused_send_zeros = 1'b0;
    logic i_power_request = 1'b0;
    logic [PIX_W-1:0] i_pixel = '0;
    logic [DLY_W-1:0] i_supply_to_link_delay = 16'h0001, i_link_to_backlight_delay = 16'h0002;
    logic [DLY_W-1:0] i_backlight_off_delay = 16'h0001, i_link_off_delay = 16'h0000;
    logic [DLY_W-1:0] i_power_cycle_delay = 16'h0001;
    logic o_panel_supply_enable, o_backlight_power_enable, o_link_active;
    logic o_link_clock_a, o_link_clock_b, o_load_strobe, o_shift_strobe;
    logic [2:0] o_lane_a, o_lane_b, o_seq_state;
    logic [3:0] o_pair_power_a, o_pair_power_b;
    logic [20:0] w_a, w_b;
    logic [6:0] w_clk;
    logic w_valid, par = 1'b0;
    logic [2:0] pc_q = 3'h0;
    logic [19:0] ev;
    logic [19:0] nx;
    logic [41:0] e;
    logic [19:0] pq[$];
    logic [41:0] eq[$];
    int n_mismatch = 0, n_compared = 0, cyc = 0;

    lvds_panel_port_sequencer dut (.*);
    panel_model u_panel (.i_clock(i_clock), .i_shift(o_shift_strobe), .i_load(o_load_strobe),
        .i_lane_a(o_lane_a), .i_lane_b(o_lane_b), .i_clk_a(o_link_clock_a),
        .o_word_a(w_a), .o_word_b(w_b), .o_clk_a(w_clk), .o_valid(w_valid));

    // Free-running clock, 40 ns period
    always #20 i_clock = ~i_clock;

    // Expected lane word from {hsync, enable, pixel}; vsync held low
    function automatic logic [20:0] mk(input logic [19:0] p);
        return {p[18], 1'b0, p[19], p[5:0], p[11:6], p[17:12]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Wait for a state; it must come d ticks after the last one, a few clocks slack
    task automatic wt(input logic [2:0] s, input logic [DLY_W-1:0] d);
        int n;
        n = 0;
        while (o_seq_state !== s && n <= d * TICK_CYCLES + 6) begin
            @(negedge i_clock);
            n++;
        end
        chk(32'(n >= d * TICK_CYCLES && n <= d * TICK_CYCLES + 6), 32'h1);
    endtask

    // Line of n random pixels, random hsync, then an even idle gap; waits for all
    task automatic burst(input int n);
        repeat (n) pq.push_back({1'($urandom), 1'b1, 18'($urandom)});
        repeat (4) pq.push_back(20'h0);
        for (int i = 0; i < 3000 && (pq.size() + eq.size()) > 0; i++) @(negedge i_clock);
        chk(32'(eq.size()), 32'h0);
    endtask

    // Pixel clock of 320 ns; a new pixel leaves at each falling pixel edge
    always @(negedge i_clock) begin
        pc_q <= pc_q + 3'h1;
        if (pc_q == 3'h3) i_pixel_clock <= 1'b1;
        if (pc_q == 3'h7) begin
            i_pixel_clock <= 1'b0;
            nx = (pq.size() > 0) ? pq.pop_front() : 20'h0;
            {i_hsync, i_display_enable, i_pixel} <= nx;
            if (!nx[18]) par = 1'b0;
            else if (!i_dual_mode) eq.push_back({mk(nx), 21'h0});
            else if (!par) {ev, par} = {nx, 1'b1};
            else begin
                // Both halves of a pair carry the control bits of its even pixel
                eq.push_back({mk(ev), mk({ev[19:18], nx[17:0]})});
                par = 1'b0;
            end
        end
    end

    // Scoreboard: words with display enable set are matched in order
    always @(negedge i_clock) begin
        if (w_valid === 1'b1 && w_a[20] === 1'b1) begin
            e = (eq.size() > 0) ? eq.pop_front() : 42'h0;
            chk(32'(w_a), 32'(e[41:21]));
            chk(32'(w_clk), 32'(CLK_PATTERN));
            chk(32'(w_b), 32'(e[20:0]));
        end
    end

    // Hang guard, well above the expected run of about 28000 clocks
    always @(negedge i_clock) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        void'($urandom(31));
        repeat (20) @(negedge i_clock);
        i_rst_b = 1'b1;
        i_port_enable = 1'b1;
        i_power_request = 1'b1;
        wt(SEQ_SUPPLY, 16'h0000);
        chk(32'(o_panel_supply_enable), 32'h1);
        wt(SEQ_LINK, i_supply_to_link_delay);
        wt(SEQ_ON, i_link_to_backlight_delay);
        chk(32'({o_backlight_power_enable, o_pair_power_b}), 32'h10);
        i_unused_send_zeros = 1'b1;
        repeat (2) @(negedge i_clock);
        chk(32'(o_pair_power_b), 32'(PAIRS_ON));
        burst(7);
        i_power_request = 1'b0;
        wt(SEQ_BL_OFF, 16'h0000);
        chk(32'({o_backlight_power_enable, o_link_active}), 32'h1);
        wt(SEQ_LINK_OFF, i_backlight_off_delay);
        wt(SEQ_CYCLE, i_link_off_delay);
        i_power_request = 1'b1;
        wt(SEQ_OFF, i_power_cycle_delay);
        wt(SEQ_SUPPLY, 16'h0000);
        i_power_request = 1'b0;
        wt(SEQ_CYCLE, 16'h0000);
        wt(SEQ_OFF, i_power_cycle_delay);
        {i_supply_to_link_delay, i_link_to_backlight_delay} = {16'h0002, 16'h0001};
        {i_backlight_off_delay, i_link_off_delay} = {16'h0000, 16'h0001};
        i_dual_mode = 1'b1;
        repeat (40 + $urandom % 8) @(negedge i_clock);
        i_power_request = 1'b1;
        wt(SEQ_SUPPLY, 16'h0000);
        wt(SEQ_LINK, i_supply_to_link_delay);
        wt(SEQ_ON, i_link_to_backlight_delay);
        chk(32'({o_pair_power_a, o_pair_power_b}), 32'h00ff);
        burst(8);
        burst(4);
        i_port_enable = 1'b0;
        wt(SEQ_BL_OFF, 16'h0000);
        repeat (2) @(negedge i_clock);
        chk(32'({o_pair_power_a, o_pair_power_b}), 32'h0);
        wt(SEQ_LINK_OFF, i_backlight_off_delay);
        wt(SEQ_CYCLE, i_link_off_delay);
        wt(SEQ_OFF, i_power_cycle_delay);
        results();
    end
endmodule // tb_top
`default_nettype wire
